/* dcc_params.svh */
// Register indexes, field positions, reset values and codes of the channel control block.
`ifndef DCC_PARAMS_SVH
`define DCC_PARAMS_SVH
`define DCC_NCH        6
`define DCC_NTRIG      19
`define DCC_IDX_SEL    8'h3f
`define DCC_IDX_CTRLA  8'h40
`define DCC_IDX_CTRLB  8'h44
`define DCC_IDX_ISTAT  8'h48
`define DCC_IDX_ICLR   8'h49
`define DCC_IDX_IEN    8'h4a
`define DCC_A_EN       1
`define DCC_A_RST      0
`define DCC_B_CMD      24
`define DCC_B_TACT     22
`define DCC_B_TSRC     8
`define DCC_B_LVL      5
`define DCC_B_EVENT_OUTPUT_ENABLE     4
`define DCC_B_EVENT_INPUT_ENABLE     3
`define DCC_B_EVENT_INPUT_ACTION    0
`define DCC_SEL_RST    3'h0
`define DCC_CTLB_RST   16'h0000
`define DCC_IRQ_RST    6'h00
`define DCC_CMD_SUSP   2'h1
`define DCC_CMD_RES    2'h2
`define DCC_TACT_RSV   2'h1
`define DCC_EV_TRIG    3'h1
`define DCC_EV_CTRIG   3'h2
`define DCC_EV_CBLOCK  3'h3
`define DCC_EV_SUSP    3'h4
`define DCC_EV_RES     3'h5
`define DCC_EV_SSKIP   3'h6
`endif

/* dcc_pkg.sv */
// Types shared by the channel control block.
package dcc_pkg;
  typedef enum logic [1:0] {CH_OFF, CH_RUN, CH_DRAIN, CH_RST} dcc_chst_t;
  typedef struct packed {
    logic [1:0] cmd;
    logic [1:0] tact;
    logic [4:0] tsrc;
    logic [1:0] lvl;
    logic       event_output_enable;
    logic       event_input_enable;
    logic [2:0] event_input_action;
  } dcc_ctlb_t;
endpackage

/* dcc_sync.sv */
// Two-stage synchroniser for a vector of asynchronous levels.
`timescale 1ns/1ps
`default_nettype none
module dcc_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second stage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* dcc_ctrl.sv */
// Per-channel control registers, trigger and event steering, arbitration of a DMA controller.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dcc_params.svh"

// Contract
// RL1: Software loads channel select before channel access.
// RL2: Reserved bits of select and controls read zero.
// RL3: Software writes zero into reserved bits.
// RL4: Enable bit write one enables channel.
// RL5: Disable waits for burst and buffer drain.
// RL6: Enable, command, level writable while enabled.
// RL7: Soft reset restores channel registers, self-clears.
// RL8: Reset ignored while enabled; zero ignored.
// RL9: Command one suspends, two resumes.
// RL10: Trigger action selects block, beat, transaction.
// RL11: Trigger source picks peripheral line; zero none.
// RL12: Higher arbitration level wins over lower.
// RL13: Event output only when output enabled.
// RL14: Event input acts only when enabled.
// RL15: Event input action code decoding.
// RL16: Separate control copies per channel, selected.
// RL17: Reserved command or action codes do nothing.
module dcc_ctrl (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output var  logic [31:0]             prdata,
  output var  logic                    pready,
  output var  logic                    pslverr,
  input  wire logic [`DCC_NTRIG-1:0]   trig_req,
  input  wire logic [`DCC_NCH-1:0]     evt_in,
  input  wire logic [`DCC_NCH-1:0]     burst_busy,
  input  wire logic [`DCC_NCH-1:0]     evt_cond,
  input  wire logic [`DCC_NCH-1:0]     chan_pend,
  output var  logic [`DCC_NCH-1:0]     chan_en,
  output var  logic [`DCC_NCH-1:0]     chan_stop_req,
  output var  logic [`DCC_NCH-1:0]     chan_trig,
  output var  logic [2*`DCC_NCH-1:0]   chan_trigger_action,
  output var  logic [`DCC_NCH-1:0]     chan_suspend,
  output var  logic [`DCC_NCH-1:0]     chan_resume,
  output var  logic [`DCC_NCH-1:0]     evt_trig,
  output var  logic [`DCC_NCH-1:0]     evt_ctrig,
  output var  logic [`DCC_NCH-1:0]     evt_cblock,
  output var  logic [`DCC_NCH-1:0]     evt_sskip,
  output var  logic [`DCC_NCH-1:0]     evt_out,
  output var  logic                    grant_valid,
  output var  logic [2:0]              grant_ch,
  output var  logic                    irq
);
  import dcc_pkg::*;

  localparam int NCH = `DCC_NCH;
  localparam int NTR = `DCC_NTRIG;

  // Byte address of a register index.
  function automatic logic [11:0] reg_addr(input logic [7:0] idx);
    reg_addr = {2'b00, idx, 2'b00};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisation and edge detection.
  logic [NTR-1:0] trig_s, trig_prev_q, trig_rise;
  logic [NCH-1:0] evt_s, evt_prev_q, evt_rise;

  dcc_sync #(.W(NTR + NCH)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({evt_in, trig_req}),
    .q       ({evt_s, trig_s})
  );

  // Rising edges are taken from the synchronised copies only.
  assign trig_rise = trig_s & ~trig_prev_q;
  assign evt_rise  = evt_s & ~evt_prev_q;

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode.
  logic       is_sel, is_a, is_b, is_stat, is_clr, is_ien, wr, chv;
  logic [2:0] sel_q, sel_d;

  assign is_sel  = paddr == reg_addr(`DCC_IDX_SEL);
  assign is_a    = paddr == reg_addr(`DCC_IDX_CTRLA);
  assign is_b    = paddr == reg_addr(`DCC_IDX_CTRLB);
  assign is_stat = paddr == reg_addr(`DCC_IDX_ISTAT);
  assign is_clr  = paddr == reg_addr(`DCC_IDX_ICLR);
  assign is_ien  = paddr == reg_addr(`DCC_IDX_IEN);
  assign wr      = psel & penable & pwrite;
  assign chv     = sel_q < 3'(NCH);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~(is_sel | is_a | is_b | is_stat | is_clr | is_ien);

  //////////////////////////////////////////////////////////////////////////////
  // Channel state and register copies.
  dcc_chst_t      st_q [NCH], st_d [NCH];
  dcc_ctlb_t      cb_q [NCH], cb_d [NCH];
  logic [5:0]     istat_q, istat_d, ien_q, ien_d;
  logic [31:0]    prdata_d;
  logic [NCH-1:0] trig_d, susp_d, res_d, eout_d, done;
  logic [NCH-1:0] etrig_d, ectrig_d, ecblk_d, esskip_d;
  logic           gv_d;
  logic [2:0]     gch_d;
  logic [1:0]     glvl;

  // Next values of every channel, the selector, interrupts and read data.
  always_comb begin
    sel_d    = sel_q;
    ien_d    = ien_q;
    done     = '0;
    trig_d   = '0;
    susp_d   = '0;
    res_d    = '0;
    etrig_d  = '0;
    ectrig_d = '0;
    ecblk_d  = '0;
    esskip_d = '0;
    eout_d   = '0;
    gv_d     = 1'b0;
    gch_d    = 3'h0;
    glvl     = 2'h0;
    if (wr && is_sel) begin
      sel_d = pwdata[2:0];
    end
    if (wr && is_ien) begin
      ien_d = pwdata[5:0];
    end
    for (int c = 0; c < NCH; c++) begin
      logic me;
      logic en;
      me    = chv && (sel_q == 3'(c)); // RL16
      en    = (st_q[c] == CH_RUN) || (st_q[c] == CH_DRAIN);
      st_d[c] = st_q[c];
      cb_d[c] = cb_q[c];
      unique case (st_q[c])
        CH_OFF: begin
          if (wr && is_a && me && pwdata[`DCC_A_EN]) begin
            st_d[c] = CH_RUN; // RL4
          end else if (wr && is_a && me && pwdata[`DCC_A_RST]) begin
            st_d[c] = CH_RST; // RL7
          end
        end
        CH_RUN: begin
          // Soft reset writes are dropped here, only the enable bit counts.
          if (wr && is_a && me && !pwdata[`DCC_A_EN]) begin // RL8
            if (burst_busy[c]) begin
              st_d[c] = CH_DRAIN; // RL5
            end else begin
              st_d[c] = CH_OFF;
              done[c] = 1'b1;
            end
          end
        end
        CH_DRAIN: begin
          if (wr && is_a && me && pwdata[`DCC_A_EN]) begin
            st_d[c] = CH_RUN;
          end else if (!burst_busy[c]) begin
            st_d[c] = CH_OFF; // RL5
            done[c] = 1'b1;
          end
        end
        CH_RST: begin
          st_d[c] = CH_OFF; // RL7
          cb_d[c] = `DCC_CTLB_RST;
        end
      endcase
      if (wr && is_b && me && st_q[c] != CH_RST) begin
        cb_d[c].cmd = pwdata[`DCC_B_CMD +: 2]; // RL6
        cb_d[c].lvl = pwdata[`DCC_B_LVL +: 2];
        if (!en) begin
          cb_d[c].tact  = pwdata[`DCC_B_TACT +: 2];
          cb_d[c].tsrc  = pwdata[`DCC_B_TSRC +: 5];
          cb_d[c].event_output_enable  = pwdata[`DCC_B_EVENT_OUTPUT_ENABLE];
          cb_d[c].event_input_enable  = pwdata[`DCC_B_EVENT_INPUT_ENABLE];
          cb_d[c].event_input_action = pwdata[`DCC_B_EVENT_INPUT_ACTION +: 3];
        end
        if (en) begin
          // Reserved command code falls through as no action.
          susp_d[c] = pwdata[`DCC_B_CMD +: 2] == `DCC_CMD_SUSP; // RL9 RL17
          res_d[c]  = pwdata[`DCC_B_CMD +: 2] == `DCC_CMD_RES;
        end
      end
      // Peripheral trigger from the selected request line.
      if (en && cb_q[c].tsrc != 5'h00 && cb_q[c].tsrc <= 5'(NTR) // RL11
          && cb_q[c].tact != `DCC_TACT_RSV) begin // RL10 RL17
        trig_d[c] = trig_rise[5'(cb_q[c].tsrc - 5'h01)];
      end
      // Event input action, only when input events are enabled.
      if (en && cb_q[c].event_input_enable && evt_rise[c]) begin // RL14
        etrig_d[c]  = cb_q[c].event_input_action == `DCC_EV_TRIG; // RL15
        ectrig_d[c] = cb_q[c].event_input_action == `DCC_EV_CTRIG;
        ecblk_d[c]  = cb_q[c].event_input_action == `DCC_EV_CBLOCK;
        esskip_d[c] = cb_q[c].event_input_action == `DCC_EV_SSKIP;
        susp_d[c]   = susp_d[c] | (cb_q[c].event_input_action == `DCC_EV_SUSP);
        res_d[c]    = res_d[c] | (cb_q[c].event_input_action == `DCC_EV_RES);
      end
      eout_d[c] = en && cb_q[c].event_output_enable && evt_cond[c]; // RL13
    end
    // Highest level wins, lowest channel number breaks a tie.
    for (int c = NCH - 1; c >= 0; c--) begin
      if (chan_pend[c] && chan_en[c] && (!gv_d || cb_q[c].lvl >= glvl)) begin // RL12
        gv_d  = 1'b1;
        gch_d = 3'(c);
        glvl  = cb_q[c].lvl;
      end
    end
    // Set wins over a clear arriving in the same cycle.
    istat_d = (istat_q & ~((wr && is_clr) ? pwdata[5:0] : 6'h00)) | done;
    prdata_d = prdata;
    if (psel && !penable && !pwrite) begin
      prdata_d = 32'h0000_0000; // RL2
      if (is_sel) begin
        prdata_d[2:0] = sel_q;
      end else if (is_a && chv) begin
        prdata_d[`DCC_A_EN]  = chan_en[sel_q];
        prdata_d[`DCC_A_RST] = st_q[sel_q] == CH_RST;
      end else if (is_b && chv) begin
        prdata_d[`DCC_B_CMD +: 2]   = cb_q[sel_q].cmd;
        prdata_d[`DCC_B_TACT +: 2]  = cb_q[sel_q].tact;
        prdata_d[`DCC_B_TSRC +: 5]  = cb_q[sel_q].tsrc;
        prdata_d[`DCC_B_LVL +: 2]   = cb_q[sel_q].lvl;
        prdata_d[`DCC_B_EVENT_OUTPUT_ENABLE]       = cb_q[sel_q].event_output_enable;
        prdata_d[`DCC_B_EVENT_INPUT_ENABLE]       = cb_q[sel_q].event_input_enable;
        prdata_d[`DCC_B_EVENT_INPUT_ACTION +: 3] = cb_q[sel_q].event_input_action;
      end else if (is_stat) begin
        prdata_d[5:0] = istat_q;
      end else if (is_ien) begin
        prdata_d[5:0] = ien_q;
      end
    end
  end

  // Registers of all state, pulses and read data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCH; c++) begin
        st_q[c] <= CH_OFF;
        cb_q[c] <= `DCC_CTLB_RST;
      end
      sel_q        <= `DCC_SEL_RST;
      istat_q      <= `DCC_IRQ_RST;
      ien_q        <= `DCC_IRQ_RST;
      prdata       <= 32'h0000_0000;
      trig_prev_q  <= '0;
      evt_prev_q   <= '0;
      chan_trig    <= '0;
      chan_suspend <= '0;
      chan_resume  <= '0;
      evt_trig     <= '0;
      evt_ctrig    <= '0;
      evt_cblock   <= '0;
      evt_sskip    <= '0;
      evt_out      <= '0;
      grant_valid  <= 1'b0;
      grant_ch     <= 3'h0;
    end else begin
      st_q         <= st_d;
      cb_q         <= cb_d;
      sel_q        <= sel_d;
      istat_q      <= istat_d;
      ien_q        <= ien_d;
      prdata       <= prdata_d;
      trig_prev_q  <= trig_s;
      evt_prev_q   <= evt_s;
      chan_trig    <= trig_d;
      chan_suspend <= susp_d;
      chan_resume  <= res_d;
      evt_trig     <= etrig_d;
      evt_ctrig    <= ectrig_d;
      evt_cblock   <= ecblk_d;
      evt_sskip    <= esskip_d;
      evt_out      <= eout_d;
      grant_valid  <= gv_d;
      grant_ch     <= gch_d;
    end
  end

  // Level outputs straight from channel state and control copies; irq from status and enable registers.
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      chan_en[c]             = (st_q[c] == CH_RUN) || (st_q[c] == CH_DRAIN);
      chan_stop_req[c]       = st_q[c] == CH_DRAIN;
      chan_trigger_action[2*c +: 2] = cb_q[c].tact;
    end
    irq = |(istat_q & ien_q);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking dflt_clk @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wr_a;
    wr && is_a && chv;
  endsequence
  sequence s_rst_run;
    (st_q[sel_q] == CH_RST) ##1 (st_q[sel_q] == CH_OFF && cb_q[sel_q] == '0);
  endsequence

  a_rsv_read_zero: assert property (psel && penable && !pwrite && (is_sel || is_a) // RL2
    |-> prdata[31:3] == 29'h0 && (is_sel || prdata[2] == 1'b0))
    else $error("Reserved bits read nonzero.");
  a_enable_write: assert property (s_wr_a and pwdata[`DCC_A_EN] |=> chan_en[sel_q]) // RL4
    else $error("Enable write did not enable the channel.");
  a_drain_hold: assert property (s_wr_a and !pwdata[`DCC_A_EN] and chan_en[sel_q] // RL5
    and burst_busy[sel_q] |=> chan_en[sel_q] && chan_stop_req[sel_q])
    else $error("Enable cleared before burst drained.");
  a_lvl_while_on: assert property (wr && is_b && chv && chan_en[sel_q] // RL6
    |=> cb_q[sel_q].lvl == $past(pwdata[`DCC_B_LVL +: 2]))
    else $error("Level not written while enabled.");
  a_channel_soft_reset_seq: assert property (s_wr_a and st_q[sel_q] == CH_OFF and pwdata[`DCC_A_RST] // RL7
    and !pwdata[`DCC_A_EN] |=> s_rst_run)
    else $error("Soft reset did not restore channel.");
  a_channel_soft_reset_ignored: assert property (s_wr_a and chan_en[sel_q] |=> st_q[sel_q] != CH_RST) // RL8
    else $error("Soft reset accepted while enabled.");
  a_cmd_suspend: assert property (wr && is_b && chv && chan_en[sel_q] // RL9
    && pwdata[`DCC_B_CMD +: 2] == `DCC_CMD_SUSP |=> chan_suspend[sel_q])
    else $error("Suspend command produced no pulse.");
  a_grant_issue: assert property (|(chan_pend & chan_en) |=> grant_valid) // RL12
    else $error("Pending enabled channel not granted.");

  for (genvar g = 0; g < NCH; g++) begin : g_chk
    a_trig_none: assert property (cb_q[g].tsrc == 5'h00 // RL11 RL10 RL17
      || cb_q[g].tact == `DCC_TACT_RSV |=> !chan_trig[g])
      else $error("Trigger from disconnected or reserved setting.");
    a_evt_in_gate: assert property (!cb_q[g].event_input_enable // RL14 RL15
      |=> !(evt_trig[g] | evt_ctrig[g] | evt_cblock[g] | evt_sskip[g]))
      else $error("Event action while event input disabled.");
    a_evt_out_gate: assert property (evt_cond[g] && chan_en[g] // RL13
      |=> evt_out[g] == $past(cb_q[g].event_output_enable))
      else $error("Event output does not follow its enable.");
  end
endmodule
`default_nettype wire

/* dcc_far_model.sv */
// Far-side model: peripheral request lines, event sources and engine status.
`timescale 1ns/1ps
`default_nettype none
`include "dcc_params.svh"
module dcc_far_model (
  input  wire logic                  pclk,
  output var  logic [`DCC_NTRIG-1:0] trig_req,
  output var  logic [`DCC_NCH-1:0]   evt_in,
  output var  logic [`DCC_NCH-1:0]   burst_busy,
  output var  logic [`DCC_NCH-1:0]   evt_cond,
  output var  logic [`DCC_NCH-1:0]   chan_pend
);
  // Every line is idle low until a test asks for activity.
  initial begin
    trig_req = '0;
    evt_in = '0;
    burst_busy = '0;
    evt_cond = '0;
    chan_pend = '0;
  end
  // A level is held three cycles so the synchroniser sees it, then it drops for a gap.
  task automatic req(input bit ev, input int k);
    @(posedge pclk);
    if (ev) evt_in[k] <= 1'b1;
    else trig_req[k] <= 1'b1;
    repeat (3) @(posedge pclk);
    if (ev) evt_in[k] <= 1'b0;
    else trig_req[k] <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  // The descriptor condition is true for one cycle only.
  task automatic cond(input int c);
    @(posedge pclk);
    evt_cond[c] <= 1'b1;
    @(posedge pclk);
    evt_cond[c] <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  // Engine busy and pending levels change together just after an edge.
  task automatic stat(input logic [`DCC_NCH-1:0] busy, input logic [`DCC_NCH-1:0] pend);
    @(posedge pclk);
    burst_busy <= busy;
    chan_pend <= pend;
  endtask
endmodule
`default_nettype wire

/* dcc_ctrl_test.sv */
// Self-checking testbench of the channel control block.
`timescale 1ns/1ps
`default_nettype none
`include "dcc_params.svh"
module dcc_ctrl_test;
  localparam logic [11:0] SEL = {`DCC_IDX_SEL, 2'b00};
  localparam logic [11:0] CA = {`DCC_IDX_CTRLA, 2'b00};
  localparam logic [11:0] CB = {`DCC_IDX_CTRLB, 2'b00};
  localparam logic [11:0] IST = {`DCC_IDX_ISTAT, 2'b00};
  localparam logic [11:0] ICL = {`DCC_IDX_ICLR, 2'b00};
  localparam logic [11:0] IEN = {`DCC_IDX_IEN, 2'b00};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, grant_valid, irq, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [`DCC_NTRIG-1:0] trig_req;
  logic [`DCC_NCH-1:0] evt_in, burst_busy, evt_cond, chan_pend, chan_en, chan_stop_req;
  logic [`DCC_NCH-1:0] chan_trig, chan_suspend, chan_resume, evt_trig, evt_ctrig;
  logic [`DCC_NCH-1:0] evt_cblock, evt_sskip, evt_out;
  logic [2*`DCC_NCH-1:0] chan_trigger_action;
  logic [2:0] grant_ch;
  int n_errors, checked;
  int cnt[8];
  int b[8];

  dcc_ctrl i_dcc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trig_req(trig_req), .evt_in(evt_in), .burst_busy(burst_busy),
    .evt_cond(evt_cond), .chan_pend(chan_pend), .chan_en(chan_en),
    .chan_stop_req(chan_stop_req), .chan_trig(chan_trig), .chan_trigger_action(chan_trigger_action),
    .chan_suspend(chan_suspend), .chan_resume(chan_resume), .evt_trig(evt_trig),
    .evt_ctrig(evt_ctrig), .evt_cblock(evt_cblock), .evt_sskip(evt_sskip),
    .evt_out(evt_out), .grant_valid(grant_valid), .grant_ch(grant_ch), .irq(irq));
  dcc_far_model i_dcc_far_model (.pclk(pclk), .trig_req(trig_req), .evt_in(evt_in),
    .burst_busy(burst_busy), .evt_cond(evt_cond), .chan_pend(chan_pend));

  // Clock of 20 ns.
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Pulse counters: event actions, peripheral triggers and event outputs.
  always @(posedge pclk) begin
    cnt[0] += $countones(evt_trig);
    cnt[1] += $countones(evt_ctrig);
    cnt[2] += $countones(evt_cblock);
    cnt[3] += $countones(chan_suspend);
    cnt[4] += $countones(chan_resume);
    cnt[5] += $countones(evt_sskip);
    cnt[6] += $countones(chan_trig);
    cnt[7] += $countones(evt_out);
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One compare with its report.
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One APB transfer; the request is held until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    cmp(nm, e, r);
  endtask
  // Compares how many pulses of one kind came since the snapshot.
  task automatic dchk(input int j, input int e);
    cmp("pulse count", 32'(e), 32'(cnt[j] - b[j]));
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Watchdog well beyond the length of the whole sequence.
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    print_verdict;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rd("select", SEL, 32'h0);
    rd("control a", CA, 32'h0);
    rd("control b", CB, 32'h0);
    wr(SEL, 32'hff);
    rd("select", SEL, 32'h7);
    wr(SEL, 32'h1);
    wr(CB, 32'hffffffff);
    rd("control b", CB, 32'h03c01f7f);
    wr(SEL, 32'h0);
    rd("other copy", CB, 32'h0);
    wr(SEL, 32'h1);
    wr(CA, 32'hfd);
    rd("control a", CA, 32'h0);
    rd("control b", CB, 32'h0);
    wr(CB, 32'h00800370);
    wr(CA, 32'h2);
    rd("control a", CA, 32'h2);
    cmp("enable", 32'h1, 32'(chan_en[1]));
    wr(CB, 32'h00c00350);
    rd("protected b", CB, 32'h00800350);
    wr(CA, 32'h3);
    rd("control a", CA, 32'h2);
    rd("control b", CB, 32'h00800350);
    // Peripheral triggers: only the selected source line starts the channel.
    b = cnt;
    i_dcc_far_model.req(1'b0, 2);
    dchk(6, 1);
    cmp("trigger action", 32'h2, 32'(chan_trigger_action[3:2]));
    b = cnt;
    i_dcc_far_model.req(1'b0, 3);
    dchk(6, 0);
    // Reserved trigger action on the connected line starts nothing.
    wr(CA, 32'h0);
    wr(CB, 32'h00400350);
    wr(CA, 32'h2);
    b = cnt;
    i_dcc_far_model.req(1'b0, 2);
    dchk(6, 0);
    // Software commands suspend, resume and the reserved code.
    for (int j = 1; j < 4; j++) begin
      b = cnt;
      wr(CB, 32'h00800350 | (j << 24));
      repeat (4) @(posedge pclk);
      dchk(3, int'(j == 1));
      dchk(4, int'(j == 2));
    end
    b = cnt;
    i_dcc_far_model.cond(1);
    dchk(7, 1);
    // Every event action code on channel 0, then one event with input disabled.
    wr(SEL, 32'h0);
    for (int a = 0; a < 9; a++) begin
      wr(CA, 32'h0);
      wr(CB, (a == 8) ? 32'h1 : 32'(8 | a));
      wr(CA, 32'h2);
      b = cnt;
      i_dcc_far_model.req(1'b1, 0);
      i_dcc_far_model.cond(0);
      for (int j = 0; j < 6; j++) dchk(j, int'(a > 0 && a < 7 && j == a - 1));
      dchk(7, 0);
    end
    // Arbitration between channel 1 at level 2 and channel 0.
    i_dcc_far_model.stat(6'h00, 6'h03);
    repeat (4) @(posedge pclk);
    cmp("grant", 32'h1, 32'(grant_ch));
    wr(CB, 32'h61);
    repeat (4) @(posedge pclk);
    cmp("grant", 32'h0, 32'(grant_ch));
    cmp("grant valid", 32'h1, 32'(grant_valid));
    // Disable while a burst runs, then the interrupt.
    wr(SEL, 32'h1);
    wr(ICL, 32'h3f);
    wr(IEN, 32'h2);
    i_dcc_far_model.stat(6'h02, 6'h00);
    wr(CA, 32'h0);
    repeat (4) @(posedge pclk);
    cmp("draining", 32'h1, 32'(chan_en[1] & chan_stop_req[1]));
    rd("control a", CA, 32'h2);
    cmp("irq", 32'h0, 32'(irq));
    i_dcc_far_model.stat(6'h00, 6'h00);
    repeat (4) @(posedge pclk);
    cmp("disabled", 32'h0, 32'(chan_en[1]));
    rd("status", IST, 32'h2);
    cmp("irq", 32'h1, 32'(irq));
    wr(IEN, 32'h0);
    cmp("irq masked", 32'h0, 32'(irq));
    wr(IEN, 32'h2);
    wr(ICL, 32'h2);
    cmp("irq cleared", 32'h0, 32'(irq));
    rd("unmapped", 12'h200, 32'h0);
    cmp("slave error", 32'h1, 32'(last_err));
    print_verdict;
  end
endmodule
`default_nettype wire
